// File: include/pbs_pkg.sv
// Shared constants, cycle kinds and carriers of the pipelined burst SRAM
package pbs_pkg;

   // ***************************************************************
   // Geometry
   // ***************************************************************
   localparam int ADDR_W     = 15;
   localparam int LANE_W     = 9;
   localparam int LANES      = 4;
   localparam int DATA_W     = LANE_W * LANES;
   localparam int FIFO_DEPTH = 32;

   // ***************************************************************
   // Burst counter and reset values
   // ***************************************************************
   localparam int             BURST_W       = 2;
   localparam logic [1:0]     COUNT_RST     = 2'h0;
   localparam logic [1:0]     COUNT_STEP    = 2'h1;
   localparam logic [14:0]    ADDR_RST      = 15'h0000;
   localparam logic [35:0]    DATA_RST      = 36'h0_0000_0000;
   localparam logic [3:0]     LANES_ALL     = 4'hf;
   localparam logic [3:0]     LANES_NONE    = 4'h0;
   localparam logic           ORDER_LINEAR  = 1'b0;

   // ***************************************************************
   // Cycle kinds decoded at each clock edge
   // ***************************************************************
   typedef enum logic [2:0] {
      CYC_DESEL    = 3'b000,
      CYC_BEGIN_RD = 3'b001,
      CYC_BEGIN_WR = 3'b010,
      CYC_CONT_RD  = 3'b011,
      CYC_CONT_WR  = 3'b100,
      CYC_SUSP_RD  = 3'b101,
      CYC_SUSP_WR  = 3'b110
   } pbs_kind_type;

   localparam pbs_kind_type KIND_RST = CYC_DESEL;

   // Control pins captured at one edge
   typedef struct packed {
      logic       ce1_n;
      logic       ce2;
      logic       ce3_n;
      logic       processor_addr_strobe_n_n;
      logic       controller_addr_strobe_n_n;
      logic       adv_n;
      logic       gw_n;
      logic       we_n;
      logic [3:0] lane_n;
   } pbs_ctl_type;

   // Decoded cycle with its address and lanes
   typedef struct packed {
      pbs_kind_type      kind;
      logic [ADDR_W-1:0] addr;
      logic [3:0]        lanes;
   } pbs_cycle_type;

endpackage : pbs_pkg

// File: verilog/pbs_sram.sv
// Pipelined burst SRAM core: read-data FIFO and cycle/burst/byte-write logic
//
// Summary of operation
// - Third enable high blocks new cycle selection
// - Burst order pin static; low linear, high interleaved
// - Output enable low drives data, high floats
// - Processor strobe begins read at external address
// - Controller strobe loads address, read or write
// - No strobe, advance low: step and continue
// - No strobe, advance high: hold, suspend burst
// - Write while suspended writes held address
// - Drive data only on read cycles
// - Output enable acts without the clock
// - Write when global low or enable with lane
// - Linear burst adds one, wraps modulo four
// - Interleaved burst xors start with step count
// - Global write all lanes, else selected lanes
// - Four byte lanes each under own enable
// - Processor strobe ignored while first enable high
// - Address, data, controls taken on rising edge
`timescale 1ns/1ps

// ******************************************************************
// Read data FIFO
// ******************************************************************
module pbs_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 32
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int PW = $clog2(DEPTH);

   // Refuse shapes the pointers cannot serve
   initial begin
      if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
         $error("pbs_fifo: DEPTH must be a power of two >= 2");
      end
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_ptr_q;
   logic [PW-1:0]    rd_ptr_q;
   logic [PW:0]      count_q;
   logic             push;
   logic             pop;

   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;
   assign o_in_ready  = (count_q != (PW+1)'(DEPTH));
   assign o_out_valid = (count_q != '0);
   assign o_out_data  = mem_q[rd_ptr_q];

   // Storage write
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + PW'(1);
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + PW'(1);
         end
         count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : pbs_fifo

// ******************************************************************
// SRAM core
// ******************************************************************
module pbs_sram #(
   parameter int AW = pbs_pkg::ADDR_W,
   parameter int FD = pbs_pkg::FIFO_DEPTH
) (
   input  wire logic                      i_core_clk,
   input  wire logic                      i_rst,
   input  wire logic [AW-1:0]             i_sync_address,
   input  wire logic                      i_primary_chip_enable_n,
   input  wire logic                      i_depth_enable_high,
   input  wire logic                      i_depth_enable_low_n,
   input  wire logic                      i_processor_addr_strobe_n,
   input  wire logic                      i_controller_addr_strobe_n,
   input  wire logic                      i_burst_advance_n,
   input  wire logic                      i_burst_order_select,
   input  wire logic                      i_global_write_n,
   input  wire logic                      i_write_enable_n,
   input  wire logic [pbs_pkg::LANES-1:0] i_lane_write_enable_n,
   input  wire logic                      i_output_enable_n,
   input  wire logic [pbs_pkg::DATA_W-1:0] i_data_io_lane,
   output logic      [pbs_pkg::DATA_W-1:0] o_data_io_lane,
   output logic                           o_data_io_lane_oe
);
   import pbs_pkg::*;

   // Refuse address widths the counter cannot serve
   initial begin
      if (AW < BURST_W + 1) begin
         $error("pbs_sram: AW too small for burst counter");
      end
   end

   // ***************************************************************
   // Functions
   // ***************************************************************
   // Burst low bits from start value and step count
   function automatic logic [1:0] burst_low(input logic [1:0] start,
                                            input logic [1:0] step,
                                            input logic       order);
      if (order == ORDER_LINEAR) begin
         return start + step;
      end
      return start ^ step;
   endfunction : burst_low

   // Lanes written this edge; none means read
   function automatic logic [3:0] write_lanes(input pbs_ctl_type c);
      if (!c.gw_n) begin
         return LANES_ALL;
      end
      if (!c.we_n) begin
         return ~c.lane_n;
      end
      return LANES_NONE;
   endfunction : write_lanes

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic [DATA_W-1:0] mem_q [2**AW];
   pbs_ctl_type       ctl;
   pbs_kind_type      kind_d;
   pbs_kind_type      kind_q;
   logic [AW-1:0]     base_d;
   logic [AW-1:0]     base_q;
   logic [1:0]        count_d;
   logic [1:0]        count_q;
   logic              active_q;
   logic [AW-1:0]     addr_d;
   logic [3:0]        lanes_d;
   logic              is_wr;
   logic              chip_sel;
   logic              processor_addr_strobe_n_go;
   logic              controller_addr_strobe_n_go;
   logic              rd_push;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [DATA_W-1:0] fifo_out_data;
   logic              drive_q;
   logic [DATA_W-1:0] dq_q;

   // ***************************************************************
   // Pin capture
   // ***************************************************************
   // Synchronous pins are in the clock domain: the edge is the capture
   assign ctl = '{ce1_n:  i_primary_chip_enable_n,
                  ce2:    i_depth_enable_high,
                  ce3_n:  i_depth_enable_low_n,
                  processor_addr_strobe_n_n: i_processor_addr_strobe_n,
                  controller_addr_strobe_n_n: i_controller_addr_strobe_n,
                  adv_n:  i_burst_advance_n,
                  gw_n:   i_global_write_n,
                  we_n:   i_write_enable_n,
                  lane_n: i_lane_write_enable_n};

   assign chip_sel = !ctl.ce1_n && ctl.ce2 && !ctl.ce3_n;
   assign processor_addr_strobe_n_go  = !ctl.processor_addr_strobe_n_n && !ctl.ce1_n;
   assign controller_addr_strobe_n_go  = !ctl.controller_addr_strobe_n_n;
   assign lanes_d  = write_lanes(ctl);
   assign is_wr    = (lanes_d != LANES_NONE);

   // ***************************************************************
   // Cycle decode
   // ***************************************************************
   // Strobes first, then burst continuation
   always_comb begin
      kind_d  = CYC_DESEL;
      base_d  = base_q;
      count_d = count_q;
      if (processor_addr_strobe_n_go) begin
         kind_d  = chip_sel ? CYC_BEGIN_RD : CYC_DESEL;
         base_d  = i_sync_address;
         count_d = COUNT_RST;
      end else if (controller_addr_strobe_n_go) begin
         kind_d  = CYC_DESEL;
         if (chip_sel) begin
            kind_d = is_wr ? CYC_BEGIN_WR : CYC_BEGIN_RD;
         end
         base_d  = i_sync_address;
         count_d = COUNT_RST;
      end else if (active_q) begin
         if (!ctl.adv_n) begin
            kind_d  = is_wr ? CYC_CONT_WR : CYC_CONT_RD;
            count_d = count_q + COUNT_STEP;
         end else begin
            kind_d = is_wr ? CYC_SUSP_WR : CYC_SUSP_RD;
         end
      end
   end

   assign addr_d = {base_d[AW-1:BURST_W],
                    burst_low(base_d[1:0], count_d, i_burst_order_select)};

   // ***************************************************************
   // Burst state
   // ***************************************************************
   // Counter, base and selection
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         base_q   <= AW'(ADDR_RST);
         count_q  <= COUNT_RST;
         kind_q   <= KIND_RST;
         active_q <= 1'b0;
      end else begin
         base_q   <= base_d;
         count_q  <= count_d;
         kind_q   <= kind_d;
         active_q <= (kind_d != CYC_DESEL);
      end
   end

   // ***************************************************************
   // Array write
   // ***************************************************************
   // per lane write; processor-strobe reads never write
   always_ff @(posedge i_core_clk) begin
      for (int l = 0; l < LANES; l++) begin
         if (kind_d != CYC_DESEL && kind_d != CYC_BEGIN_RD && lanes_d[l]) begin
            mem_q[addr_d][l*LANE_W +: LANE_W] <= i_data_io_lane[l*LANE_W +: LANE_W];
         end
      end
   end

   // ***************************************************************
   // Read pipeline
   // ***************************************************************
   // Read words queue for the output register
   assign rd_push = (kind_d == CYC_BEGIN_RD || kind_d == CYC_CONT_RD
                     || kind_d == CYC_SUSP_RD) && fifo_in_ready;

   pbs_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FD)
   ) u_rd_fifo (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_in_valid  (rd_push),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (mem_q[addr_d]),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (1'b1),
      .o_out_data  (fifo_out_data)
   );

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         dq_q <= DATA_RST;
      end else if (fifo_out_valid) begin
         dq_q <= fifo_out_data;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= fifo_out_valid
                    && (kind_d == CYC_CONT_RD || kind_d == CYC_SUSP_RD);
      end
   end

   assign o_data_io_lane = dq_q;
   assign o_data_io_lane_oe = drive_q && !i_output_enable_n;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   desel_float_a: assert property (
      (kind_q == CYC_DESEL) |-> !o_data_io_lane_oe)
      else $error("deselect cycle drives data");

   begin_hiz_a: assert property (
      (kind_q == CYC_BEGIN_RD || kind_q == CYC_BEGIN_WR) |-> !o_data_io_lane_oe)
      else $error("begin cycle drives data");

   ce3_block_a: assert property (
      (!i_controller_addr_strobe_n && i_depth_enable_low_n) |=> kind_q == CYC_DESEL)
      else $error("third enable high did not deselect");

   processor_addr_strobe_n_ignore_a: assert property (
      (!i_processor_addr_strobe_n && i_primary_chip_enable_n
       && i_controller_addr_strobe_n && active_q)
      |=> kind_q != CYC_DESEL && kind_q != CYC_BEGIN_RD)
      else $error("processor strobe acted with first enable high");

   ext_load_a: assert property (
      (i_processor_addr_strobe_n && !i_controller_addr_strobe_n && chip_sel)
      |=> base_q == $past(i_sync_address) && count_q == COUNT_RST
          && (kind_q == CYC_BEGIN_RD || kind_q == CYC_BEGIN_WR))
      else $error("controller strobe did not load address");

   step_a: assert property (
      (!processor_addr_strobe_n_go && !controller_addr_strobe_n_go && active_q && !i_burst_advance_n)
      |=> count_q == $past(count_q) + COUNT_STEP && $stable(base_q))
      else $error("burst did not step");

   hold_a: assert property (
      (!processor_addr_strobe_n_go && !controller_addr_strobe_n_go && active_q && i_burst_advance_n)
      |=> $stable(count_q) && $stable(base_q))
      else $error("suspended burst moved");

   global_wr_a: assert property (
      (!i_global_write_n && !processor_addr_strobe_n_go && !controller_addr_strobe_n_go && active_q)
      |=> kind_q == CYC_CONT_WR || kind_q == CYC_SUSP_WR)
      else $error("global write not taken as write");

   oe_async_a: assert property (
      i_output_enable_n |-> !o_data_io_lane_oe)
      else $error("data driven with output enable high");

   rd_latency_a: assert property (
      (kind_q == CYC_BEGIN_RD && kind_d == CYC_CONT_RD) |=> drive_q)
      else $error("read data not ready one clock later");

   wrap_a: assert property (
      (kind_q == CYC_BEGIN_RD && !i_burst_order_select)
      ##1 (kind_q == CYC_CONT_RD) [*4] |-> count_q == COUNT_RST)
      else $error("linear burst did not wrap after four");

   rd_burst_c: cover property (
      kind_q == CYC_BEGIN_RD ##1 kind_q == CYC_CONT_RD [*3]);
   wr_burst_c: cover property (
      kind_q == CYC_BEGIN_WR ##1 kind_q == CYC_CONT_WR [*3]);
   susp_wr_c: cover property (
      kind_q == CYC_SUSP_RD ##1 kind_q == CYC_SUSP_WR);
   desel_c: cover property (
      kind_q == CYC_CONT_RD ##1 kind_q == CYC_DESEL);
endmodule : pbs_sram

// File: bench/pbs_host_model.sv
// Processor-side model that drives the burst SRAM pins
`timescale 1ns/1ps
module pbs_host_model (
   input  wire logic                  i_core_clk,
   output pbs_pkg::pbs_ctl_type       o_ctl,
   output logic [pbs_pkg::ADDR_W-1:0] o_addr,
   output logic [pbs_pkg::DATA_W-1:0] o_data,
   output logic                       o_oe_n,
   output logic                       o_order
);
   import pbs_pkg::*;
   // Idle controls: enabled, no strobe, hold, read
   localparam pbs_ctl_type IDLE_CTL = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf};
   // no sleep pin, board ties it low
   initial begin
      o_ctl   = IDLE_CTL;
      o_addr  = ADDR_RST;
      o_data  = DATA_RST;
      o_oe_n  = 1'b1;
      o_order = ORDER_LINEAR;
   end
   task automatic cyc(input pbs_ctl_type c, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      logic wr;
      @(posedge i_core_clk);
      #2;
      wr = (!c.gw_n || (!c.we_n && c.lane_n != LANES_ALL)) && !(!c.processor_addr_strobe_n_n && !c.ce1_n);
      if (wr) begin
         o_oe_n = 1'b1;
      end
      o_ctl  = c;
      o_addr = a;
      // Undriven bus shows a changing pattern
      o_data = wr ? d : ~o_data;
   endtask : cyc
   task automatic set_oe(input logic v);
      o_oe_n = v;
   endtask : set_oe
   task automatic set_order(input logic v);
      o_order = v;
   endtask : set_order
endmodule : pbs_host_model

// File: bench/pbs_sram_test.sv
// Self-checking testbench of the pipelined burst SRAM core
`timescale 1ns/1ps
module pbs_sram_test;
   import pbs_pkg::*;
   localparam pbs_ctl_type       IDLE = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf};
   localparam logic [ADDR_W-1:0] BASE = 15'h1a4c;
   logic              clk;
   logic              rst;
   pbs_ctl_type       ctl;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] din;
   logic [DATA_W-1:0] dout;
   logic              oe_n;
   logic              order;
   logic              oe;
   logic              ce1_n, ce2, ce3_n, processor_addr_strobe_n_n, controller_addr_strobe_n_n, adv_n, gw_n, we_n;
   logic [DATA_W-1:0] ref_q [0:3];
   int                n_fail;
   int                n_checks;
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   pbs_host_model host (.i_core_clk(clk), .o_ctl(ctl), .o_addr(addr), .o_data(din),
                        .o_oe_n(oe_n), .o_order(order));
   // Control pins unpacked from the host carrier
   assign {ce1_n, ce2, ce3_n, processor_addr_strobe_n_n} = {ctl.ce1_n, ctl.ce2, ctl.ce3_n, ctl.processor_addr_strobe_n_n};
   assign {controller_addr_strobe_n_n, adv_n, gw_n, we_n} = {ctl.controller_addr_strobe_n_n, ctl.adv_n, ctl.gw_n, ctl.we_n};
   pbs_sram #(.AW(ADDR_W), .FD(FIFO_DEPTH)) uut (
      .i_core_clk(clk), .i_rst(rst), .i_sync_address(addr),
      .i_primary_chip_enable_n(ce1_n), .i_depth_enable_high(ce2),
      .i_depth_enable_low_n(ce3_n), .i_processor_addr_strobe_n(processor_addr_strobe_n_n),
      .i_controller_addr_strobe_n(controller_addr_strobe_n_n), .i_burst_advance_n(adv_n),
      .i_burst_order_select(order), .i_global_write_n(gw_n),
      .i_write_enable_n(we_n), .i_lane_write_enable_n(ctl.lane_n),
      .i_output_enable_n(oe_n), .i_data_io_lane(din), .o_data_io_lane(dout),
      .o_data_io_lane_oe(oe));
   // ***************************************************************
   // Checking and closing
   // ***************************************************************
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test;
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic rd_burst(input logic [ADDR_W-1:0] a, input logic by_proc);
      pbs_ctl_type c;
      int          k;
      logic [1:0]  lo;
      c = IDLE;
      c.processor_addr_strobe_n_n = ~by_proc;
      c.controller_addr_strobe_n_n = by_proc;
      host.cyc(c, a, 36'h0);
      host.set_oe(1'b0);
      c = IDLE;
      c.adv_n = 1'b0;
      host.cyc(c, 15'h7fff, 36'h0);
      chk({35'h0, oe}, 36'h0);
      for (k = 0; k < 4; k++) begin
         host.cyc(c, 15'h7fff, 36'h0);
         lo = order ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
         chk({35'h0, oe}, 36'h1);
         chk(dout, ref_q[lo]);
      end
      host.cyc(IDLE, 15'h7fff, 36'h0);
   endtask : rd_burst
   task automatic s_burst;
      pbs_ctl_type c;
      int          k;
      c = IDLE;
      c.controller_addr_strobe_n_n = 1'b0;
      c.gw_n = 1'b0;
      c.we_n = 1'b0;
      c.lane_n = 4'he;
      host.cyc(c, BASE | 15'h1, 36'h9_2468_ace0);
      c.controller_addr_strobe_n_n = 1'b1;
      c.adv_n = 1'b0;
      for (k = 1; k < 4; k++) begin
         host.cyc(c, 15'h7fff, 36'h9_2468_ace0 + 36'(k));
      end
      for (k = 0; k < 4; k++) begin
         ref_q[(k + 1) % 4] = 36'h9_2468_ace0 + 36'(k);
      end
      rd_burst(BASE, 1'b0);
      host.set_order(1'b1);
      rd_burst(BASE | 15'h2, 1'b1);
      host.set_order(1'b0);
   endtask : s_burst
   task automatic s_suspend;
      pbs_ctl_type c;
      c = IDLE;
      c.controller_addr_strobe_n_n = 1'b0;
      host.set_oe(1'b0);
      host.cyc(c, BASE | 15'h2, 36'h0);
      c = IDLE;
      c.adv_n = 1'b0;
      host.cyc(c, 15'h7fff, 36'h0);
      host.cyc(IDLE, 15'h7fff, 36'h0);
      host.cyc(IDLE, 15'h7fff, 36'h0);
      host.cyc(IDLE, 15'h7fff, 36'h0);
      chk(dout, ref_q[3]);
      host.set_oe(1'b1);
      #1 chk({35'h0, oe}, 36'h0);
      // Output enable acts between edges, an edge alone never drives
      host.cyc(IDLE, 15'h7fff, 36'h0);
      chk({35'h0, oe}, 36'h0);
      host.set_oe(1'b0);
      #1 chk({35'h0, oe}, 36'h1);
      c = IDLE;
      c.gw_n = 1'b0;
      host.cyc(c, 15'h7fff, 36'h5_a5a5_a5a5);
      ref_q[3] = 36'h5_a5a5_a5a5;
      host.cyc(IDLE, 15'h7fff, 36'h0);
      host.set_oe(1'b0);
      #1 chk({35'h0, oe}, 36'h0);
      rd_burst(BASE, 1'b0);
   endtask : s_suspend
   task automatic s_lanes;
      pbs_ctl_type       c;
      int                i;
      logic [DATA_W-1:0] m;
      for (i = 0; i < 6; i++) begin
         c = IDLE;
         c.controller_addr_strobe_n_n = 1'b0;
         c.we_n = (i == 4);
         c.lane_n = (i < 4) ? ~(4'h1 << i) : ((i == 4) ? 4'h0 : 4'hf);
         host.cyc(c, BASE | 15'(i % 4), 36'h6_3c3c_3c3c ^ 36'(i));
         m = {27'h0, 9'h1ff} << (9 * i);
         if (i < 4) ref_q[i] = (ref_q[i] & ~m) | ((36'h6_3c3c_3c3c ^ 36'(i)) & m);
      end
      rd_burst(BASE, 1'b0);
   endtask : s_lanes
   task automatic s_desel;
      pbs_ctl_type c;
      int          i;
      for (i = 0; i < 5; i++) begin
         c = IDLE;
         c.controller_addr_strobe_n_n = 1'b0;
         host.set_oe(1'b0);
         host.cyc(c, BASE, 36'h0);
         c = IDLE;
         case (i)
            0: c.ce1_n = 1'b1;
            1: c.ce3_n = 1'b1;
            2: c.ce2 = 1'b0;
            3: c.ce3_n = 1'b1;
            default: c.ce2 = 1'b0;
         endcase
         c.processor_addr_strobe_n_n = (i == 0 || i > 2);
         c.controller_addr_strobe_n_n = (i == 1 || i == 2);
         host.cyc(c, BASE, 36'h0);
         c = IDLE;
         c.adv_n = 1'b0;
         host.cyc(c, 15'h7fff, 36'h0);
         host.cyc(c, 15'h7fff, 36'h0);
         chk({35'h0, oe}, 36'h0);
      end
      c = IDLE;
      c.processor_addr_strobe_n_n = 1'b0;
      c.gw_n = 1'b0;
      host.cyc(c, BASE | 15'h2, 36'h0);
      c.ce1_n = 1'b1;
      c.gw_n = 1'b1;
      c.adv_n = 1'b0;
      host.cyc(c, 15'h7fff, 36'h0);
      host.cyc(IDLE, 15'h7fff, 36'h0);
      chk({35'h0, oe}, 36'h1);
      chk(dout, ref_q[2]);
   endtask : s_desel
   // Main sequence
   initial begin
      n_fail = 0;
      n_checks = 0;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      #2 rst = 1'b0;
      chk(dout, DATA_RST);
      s_burst;
      s_suspend;
      s_lanes;
      s_desel;
      end_of_test;
   end
   // Watchdog against a hang
   initial begin
      repeat (2000) @(posedge clk);
      n_fail++;
      end_of_test;
   end
endmodule : pbs_sram_test
